//--- include/tse_pkg.sv
// Package for the two-stage event controller: register offsets,
// reset values and event counts.
// Assumes a single core clock and word-wide register access.
`default_nettype none
package tse_pkg;
   // Event counts
   localparam int NCORE = 16;
   localparam int NPER  = 64;
   localparam int NGEN  = 9;
   localparam int GEN0  = 7;
   // Register byte offsets within the block window
   localparam logic [7:0] OFS_LATCH = 8'h00;
   localparam logic [7:0] OFS_MASK  = 8'h04;
   localparam logic [7:0] OFS_PEND  = 8'h08;
   localparam logic [7:0] OFS_CTRL  = 8'h0C;
   localparam logic [7:0] OFS_PMSK0 = 8'h10;
   localparam logic [7:0] OFS_PMSK1 = 8'h14;
   localparam logic [7:0] OFS_STAT0 = 8'h18;
   localparam logic [7:0] OFS_STAT1 = 8'h1C;
   localparam logic [7:0] OFS_WAKE0 = 8'h20;
   localparam logic [7:0] OFS_WAKE1 = 8'h24;
   localparam logic [2:0] ASG_BLK   = 3'h2;
   // Reset values
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [63:0] PMSK_RST = 64'h0000_0000_0000_0000;
   localparam logic [63:0] WAKE_RST = 64'h0000_0000_0000_0000;
   localparam logic        GIE_RST  = 1'b1;
   // Events 0..4 cannot be masked
   localparam logic [15:0] FIXED_EN = 16'h001F;
   // Default level codes, one nibble per source, code 0 = level 7
   localparam logic [255:0] ASG_RST = {
      32'hFFFF_FFFF, 32'hFFFF_F666, 32'h6654_4444, 32'h4444_4333,
      32'h3333_3322, 32'h2222_2211, 32'h0000_0000,
      32'h0000_0000}; // RULE4 RULE5 RULE6 RULE7 RULE8
endpackage : tse_pkg
`default_nettype wire

//--- logic/tse_event_ctrl.sv
// Two-stage event controller: system stage routes peripheral
// requests onto nine general levels, core stage latches, masks,
// nests and presents events to the pipeline; AHB-Lite registers.
// Assumes all inputs synchronous to i_clk; privileged access by hprot[1].
// Contract
// RULE1 - Nine general inputs, levels 7 to 15, beside dedicated core events.
// RULE2 - Software should keep levels 14 and 15 for software handlers.
// RULE3 - Fixed priority, 0 highest, general levels in numeric order.
// RULE4 - Wake-up and peripheral error sources default to level 7.
// RULE5 - Clock and parallel DMA to level 8; serial DMA to level 9.
// RULE6 - Serial peripheral and UART DMA events default to level 10.
// RULE7 - Timers, two-wire, CAN data and media status default to level 11.
// RULE8 - Flags to level 12; memory DMA streams and watchdog to 13.
// RULE9 - Assignment registers let software remap each source's level.
// RULE10 - Latch register bit sets on event, clears when accepted.
// RULE11 - Privileged writes cancel latched events whose mask bit is clear.
// RULE12 - Mask bit set allows servicing; clear blocks it but latches. Events 0 to 4 are serviced whatever their mask bit.
// RULE13 - Global enable and disable of general levels by instructions.
// RULE14 - Pending register, hardware only, marks active or nested events.
// RULE15 - Peripheral mask registers, one bit per source, gate servicing.
// RULE16 - Peripheral status registers show each source's request level.
// RULE17 - Wake-up enable bits let a source wake an idle core.
// RULE18 - System stage takes pending bits as the acknowledgement.
// RULE19 - Rising edge sets latch bit; detection takes two cycles.
// RULE20 - Latch bit clears when pending sets; next edge is queued.
// RULE21 - Edge to pending takes at least three cycles.
// RULE22 - Nesting supported; higher priority takes precedence.
// RULE23 - Pick lowest unmasked latched event above all active ones.
// RULE24 - Each general input is OR of unmasked sources assigned there.
`timescale 1ns/1ps
`default_nettype none
module tse_event_ctrl (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // AHB-Lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [3:0]  i_hprot,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   // Event sources
   input  wire logic [6:0]  i_core_evt,
   input  wire logic [63:0] i_per_req,
   // Processor pipeline
   output logic             o_evt_req,
   output logic [3:0]       o_evt_num,
   input  wire logic        i_evt_ack,
   input  wire logic        i_evt_ret,
   input  wire logic [3:0]  i_ret_num,
   input  wire logic        i_gie_set,
   input  wire logic        i_gie_clr,
   input  wire logic        i_core_idle,
   output logic             o_wakeup,
   output logic [15:0]      o_evt_pending
);

   typedef struct packed {
      logic [15:0]      in_q;
      logic [15:0]      in_qq;
      logic [15:0]      latch;
      logic [15:0]      mask;
      logic [15:0]      pend;
      logic [15:0]      pend_p;
      logic             gie;
      logic             req;
      logic [3:0]       num;
      logic [63:0]      pmask;
      logic [63:0]      wake;
      logic [63:0][3:0] asg;
      logic [8:0]       gen;
      logic             wk;
      logic             a_vld;
      logic [7:0]       a_addr;
      logic             a_priv;
      logic [31:0]      rdata;
   } tse_state_s;

   logic [1:0]  rs_q;
   logic        rst_n;
   tse_state_s  s_q;
   tse_state_s  n;
   logic        acc;
   logic [15:0] cin;
   logic [15:0] rise;
   logic [15:0] clr;
   logic [15:0] ack_m;
   logic [15:0] ret_m;
   logic [15:0] en;
   logic [15:0] cand;
   logic [4:0]  pk;
   logic [4:0]  lp;
   logic        hit;

   // Lowest set index with found flag
   function automatic logic [4:0] lowest(input logic [15:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction : lowest

   // Register read decode; nothing visible without privilege
   function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                          input logic       p);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (p) begin
         if (a[7:5] == tse_pkg::ASG_BLK) begin
            d = s_q.asg[a[4:2]*8 +: 8];
         end else begin
            unique case (a)
               tse_pkg::OFS_LATCH: d = {16'h0000, s_q.latch};
               tse_pkg::OFS_MASK:  d = {16'h0000, s_q.mask};
               tse_pkg::OFS_PEND:  d = {16'h0000, s_q.pend}; // RULE14
               tse_pkg::OFS_CTRL:  d = {31'h0000_0000, s_q.gie};
               tse_pkg::OFS_PMSK0: d = s_q.pmask[31:0];
               tse_pkg::OFS_PMSK1: d = s_q.pmask[63:32];
               tse_pkg::OFS_STAT0: d = i_per_req[31:0]; // RULE16
               tse_pkg::OFS_STAT1: d = i_per_req[63:32]; // RULE16
               tse_pkg::OFS_WAKE0: d = s_q.wake[31:0];
               tse_pkg::OFS_WAKE1: d = s_q.wake[63:32];
               default:            d = 32'h0000_0000;
            endcase
         end
      end
      return d;
   endfunction : rd_mux

   // Reset release through two flops
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rs_q <= 2'b00;
      end else begin
         rs_q <= {rs_q[0], 1'b1};
      end
   end
   assign rst_n = rs_q[1];

   // Core inputs: general levels above, dedicated below, 4 reserved
   assign cin = {s_q.gen, i_core_evt[6:5], 1'b0, i_core_evt[3:0]}; // RULE1 RULE3

   // Next-state logic
   always_comb begin
      n     = s_q;
      clr   = 16'h0000;
      hit   = 1'b0;
      // Address phase capture and read data
      acc      = i_hsel & i_htrans[1] & i_hready;
      n.a_vld  = acc & i_hwrite;
      n.a_addr = i_haddr[7:0];
      n.a_priv = i_hprot[1];
      n.rdata  = (acc & ~i_hwrite) ? rd_mux(i_haddr[7:0], i_hprot[1])
                                   : 32'h0000_0000;
      // Data phase writes, privileged only
      if (s_q.a_vld && s_q.a_priv) begin
         if (s_q.a_addr[7:5] == tse_pkg::ASG_BLK) begin
            n.asg[s_q.a_addr[4:2]*8 +: 8] = i_hwdata; // RULE9
         end else begin
            unique case (s_q.a_addr)
               tse_pkg::OFS_LATCH: clr = i_hwdata[15:0] & ~s_q.mask; // RULE11
               tse_pkg::OFS_MASK:  n.mask = i_hwdata[15:0]; // RULE12
               tse_pkg::OFS_PMSK0: n.pmask[31:0] = i_hwdata; // RULE15
               tse_pkg::OFS_PMSK1: n.pmask[63:32] = i_hwdata; // RULE15
               tse_pkg::OFS_WAKE0: n.wake[31:0] = i_hwdata;
               tse_pkg::OFS_WAKE1: n.wake[63:32] = i_hwdata;
               default: ;
            endcase
         end
      end
      // Edge detection over two cycles
      n.in_q  = cin; // RULE21
      n.in_qq = s_q.in_q;
      rise    = s_q.in_q & ~s_q.in_qq; // RULE19
      // Acknowledge and return
      ack_m = (s_q.req & i_evt_ack) ? 16'(16'h0001 << s_q.num) : 16'h0000;
      ret_m = i_evt_ret ? 16'(16'h0001 << i_ret_num) : 16'h0000;
      n.pend   = (s_q.pend & ~ret_m) | ack_m; // RULE14 RULE22
      n.pend_p = s_q.pend;
      // New edges win over cancel and accept
      n.latch = (s_q.latch & ~clr & ~ack_m) | rise; // RULE10 RULE20
      // Global enable of general levels
      if (i_gie_set) begin
         n.gie = 1'b1; // RULE13
      end else if (i_gie_clr) begin
         n.gie = 1'b0; // RULE13
      end
      en = n.mask | tse_pkg::FIXED_EN; // RULE12
      if (!n.gie) begin
         en[15:7] = 9'h000; // RULE13
      end
      // Priority pick against active nesting level
      cand  = s_q.latch & ~clr & ~ack_m & en;
      pk    = lowest(cand); // RULE3
      lp    = lowest(n.pend);
      n.req = pk[4] & (~lp[4] | (pk[3:0] < lp[3:0])); // RULE23 RULE22
      n.num = pk[3:0];
      // System stage routing; drops a level for one cycle on accept
      for (int c = 0; c < tse_pkg::NGEN; c++) begin
         hit = 1'b0;
         for (int e = 0; e < tse_pkg::NPER; e++) begin
            hit = hit | (i_per_req[e] & s_q.pmask[e]
                         & (s_q.asg[e] == 4'(c))); // RULE24 RULE15
         end
         n.gen[c] = hit & ~(s_q.pend[c+tse_pkg::GEN0]
                            & ~s_q.pend_p[c+tse_pkg::GEN0]); // RULE18
      end
      // Wake-up from idle
      n.wk = i_core_idle & (|(i_per_req & s_q.wake)); // RULE17
   end

   // State register
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q       <= '0;
         s_q.mask  <= tse_pkg::MASK_RST;
         s_q.pmask <= tse_pkg::PMSK_RST;
         s_q.wake  <= tse_pkg::WAKE_RST;
         s_q.gie   <= tse_pkg::GIE_RST;
         s_q.asg   <= tse_pkg::ASG_RST; // RULE4 RULE5 RULE6 RULE7 RULE8
      end else begin
         s_q <= n;
      end
   end

   // Outputs
   assign o_hreadyout   = 1'b1;
   assign o_hresp       = 1'b0;
   assign o_hrdata      = s_q.rdata;
   assign o_evt_req     = s_q.req;
   assign o_evt_num     = s_q.num;
   assign o_wakeup      = s_q.wk;
   assign o_evt_pending = s_q.pend;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   property p_edge_latch;
      (s_q.in_q[7] && !s_q.in_qq[7]) |=> s_q.latch[7];
   endproperty
   a_edge_latch: assert property (p_edge_latch) // RULE19
      else $error("edge on level 7 not latched");

   property p_accept;
      (s_q.req && i_evt_ack) |=> s_q.pend[$past(s_q.num)];
   endproperty
   a_accept: assert property (p_accept) // RULE20
      else $error("accepted event not pending");

   property p_latency;
      $rose(s_q.pend[7]) |-> $past(s_q.latch[7]) && $past(s_q.in_q[7], 2);
   endproperty
   a_latency: assert property (p_latency) // RULE21
      else $error("pending set without latched edge");

   property p_global;
      !s_q.gie |-> !(s_q.req && s_q.num >= 4'h7);
   endproperty
   a_global: assert property (p_global) // RULE13
      else $error("general level offered while disabled");

   property p_masked;
      s_q.req |-> (s_q.mask[s_q.num] || s_q.num < 4'h5);
   endproperty
   a_masked: assert property (p_masked) // RULE12
      else $error("masked event offered");

   property p_nest;
      s_q.req |-> (s_q.pend & 16'(16'(16'h0002 << s_q.num) - 16'h0001)) == 16'h0000;
   endproperty
   a_nest: assert property (p_nest) // RULE23
      else $error("offered event not above active level");

   property p_pend_hw;
      (s_q.pend != $past(s_q.pend)) |-> $past(i_evt_ack || i_evt_ret);
   endproperty
   a_pend_hw: assert property (p_pend_hw) // RULE14
      else $error("pending changed without core action");

   property p_wake;
      o_wakeup |-> $past(i_core_idle);
   endproperty
   a_wake: assert property (p_wake) // RULE17
      else $error("wake-up while core not idle");

   property p_share;
      $rose(s_q.pend[8]) |=> !s_q.gen[1];
   endproperty
   a_share: assert property (p_share) // RULE18
      else $error("level 8 not re-armed on acknowledge");

   // Accepted event leaves the latch unless a new edge arrived
   property p_latch_clr;
      (s_q.req && i_evt_ack && !rise[s_q.num]) |=> !s_q.latch[$past(s_q.num)];
   endproperty
   a_latch_clr: assert property (p_latch_clr) // RULE10
      else $error("accepted event still latched");

   // Accepted event is not offered again in the cycle after acceptance
   property p_req_drop;
      (s_q.req && i_evt_ack) |=> (!s_q.req || s_q.num != $past(s_q.num));
   endproperty
   a_req_drop: assert property (p_req_drop) // RULE20
      else $error("accepted event offered twice");

   // Reserved slot never latches
   property p_reserved;
      !s_q.latch[4];
   endproperty
   a_reserved: assert property (p_reserved) // RULE3
      else $error("reserved event latched");

   // Unprivileged writes leave masks unchanged
   property p_nonpriv_wr;
      (s_q.a_vld && !s_q.a_priv) |=> (s_q.mask == $past(s_q.mask)) && (s_q.pmask == $past(s_q.pmask));
   endproperty
   a_nonpriv_wr: assert property (p_nonpriv_wr) // RULE11
      else $error("unprivileged write changed a mask");

   // Unprivileged reads see nothing
   property p_priv_read;
      !$past(i_hprot[1]) |-> (o_hrdata == 32'h0000_0000);
   endproperty
   a_priv_read: assert property (p_priv_read) // RULE14
      else $error("register visible without privilege");

   // No unmasked request leaves every general level low
   property p_gen_off;
      !(|(i_per_req & s_q.pmask)) |=> (s_q.gen == 9'h000);
   endproperty
   a_gen_off: assert property (p_gen_off) // RULE24
      else $error("general level high without request");

   // Idle core with an enabled request raises wake-up
   property p_wake_on;
      $past(i_core_idle && (|(i_per_req & s_q.wake))) |-> o_wakeup;
   endproperty
   a_wake_on: assert property (p_wake_on) // RULE17
      else $error("enabled source did not wake idle core");

   // Enable instruction turns general levels on
   property p_gie_set;
      $past(i_gie_set) |-> s_q.gie;
   endproperty
   a_gie_set: assert property (p_gie_set) // RULE13
      else $error("global enable not applied");

   // Return clears its pending bit unless re-accepted at once
   property p_ret;
      ($past(i_evt_ret) && !$past(s_q.req && i_evt_ack && (s_q.num == i_ret_num)))
         |-> !s_q.pend[$past(i_ret_num)];
   endproperty
   a_ret: assert property (p_ret) // RULE14
      else $error("returned event still pending");

   // Scenario coverage
   c_accept: cover property (s_q.req && i_evt_ack);
   c_block:  cover property (s_q.latch[5] && !s_q.mask[5]);
   c_rearm:  cover property ($rose(s_q.pend[9]));
   c_nested: cover property ($countones(s_q.pend) >= 2);
   c_wake:   cover property (o_wakeup);

endmodule : tse_event_ctrl
`default_nettype wire

//--- tb/tse_core_model.sv
// Core pipeline model: accepts each offered event.
// Assumes the controller drops its offer on the accepting edge.
`timescale 1ns/1ps
`default_nettype none
module tse_core_model (
   // Clock, reset and pace
   input  wire logic i_clk,
   input  wire logic i_resetn,
   input  wire logic i_slow,
   // Offer and accept
   input  wire logic i_evt_req,
   output logic      o_evt_ack
);
   logic [1:0] wait_q;
   // Accept at once, or after three cycles when slow
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_evt_ack <= 1'h0;
         wait_q    <= 2'h0;
      end else begin
         o_evt_ack <= i_evt_req & ~o_evt_ack & (~i_slow | (wait_q == 2'h3));
         wait_q    <= (i_evt_req & ~o_evt_ack) ? wait_q + 2'h1 : 2'h0;
      end
   end
endmodule : tse_core_model
`default_nettype wire

//--- tb/test_two_stage_event_controller.sv
// Self-checking bench: registers over AHB-Lite, event latency,
// masking, nesting, routing, global enable and wake-up.
// Assumes the core model accepts every offered event.
`timescale 1ns/1ps
`default_nettype none
module test_two_stage_event_controller;
   logic        clk, rstn, hrdy, hresp, req, ack, slow, idle, wake, gset, gclr, ret, hwrite;
   logic [1:0]  htrans;
   logic [3:0]  prot, num, rnum;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [6:0]  cev;
   logic [63:0] per;
   logic [15:0] pend;
   int          fails, compares, n;

   tse_event_ctrl dut_u (.i_clk(clk), .i_resetn(rstn), .i_hsel(1'h1), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hprot(prot), .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
      .o_hresp(hresp), .o_hrdata(hrdata), .i_core_evt(cev), .i_per_req(per), .o_evt_req(req),
      .o_evt_num(num), .i_evt_ack(ack), .i_evt_ret(ret), .i_ret_num(rnum), .i_gie_set(gset),
      .i_gie_clr(gclr), .i_core_idle(idle), .o_wakeup(wake), .o_evt_pending(pend));
   tse_core_model core_u (.i_clk(clk), .i_resetn(rstn), .i_slow(slow), .i_evt_req(req), .o_evt_ack(ack));

   // Clock
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // One single AHB-Lite transfer
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hrdy !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'h1);
      q = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'h0, 32'h0);
      chk(q, e);
   endtask : rd
   // Waits, bounded, until pending leaves a value
   task automatic wpend(input logic [15:0] old);
      n = 0;
      while (pend === old && n < 60) begin
         @(posedge clk);
         n++;
      end
   endtask : wpend
   // One-cycle pulses on core events or a return
   task automatic pulse(input logic [6:0] v);
      @(posedge clk);
      cev <= v;
      @(posedge clk);
      cev <= 7'h0;
   endtask : pulse
   task automatic fin(input logic [3:0] e);
      @(posedge clk);
      ret  <= 1'h1;
      rnum <= e;
      @(posedge clk);
      ret  <= 1'h0;
      per  <= 64'h0;
      repeat (4) @(posedge clk);
   endtask : fin
   // Default level code per source
   function automatic logic [3:0] lvl(input int s);
      if (s < 16) return 4'h0;
      if (s < 18) return 4'h1;
      if (s < 26) return 4'h2;
      if (s < 35) return 4'h3;
      if (s < 45) return 4'h4;
      if (s < 46) return 4'h5;
      if (s < 51) return 4'h6;
      return 4'hF;
   endfunction : lvl
   task automatic t_reset();
      logic [31:0] e;
      rd(tse_pkg::OFS_MASK, 32'h0);
      rd(tse_pkg::OFS_PEND, 32'h0);
      rd(tse_pkg::OFS_CTRL, 32'h1);
      rd(tse_pkg::OFS_PMSK1, 32'h0);
      rd(8'h30, 32'h0);
      for (int r = 0; r < 8; r++) begin
         for (int k = 0; k < 8; k++) e[4*k +: 4] = lvl(8 * r + k);
         rd(8'h40 + 8'(4 * r), e);
      end
   endtask : t_reset
   // Two events at once: higher priority first, lower waits
   task automatic t_core();
      bus(tse_pkg::OFS_MASK, 1'h1, 32'h60);
      pulse(7'h60);
      wpend(16'h0);
      chk({31'h0, n >= 2}, 32'h1);
      chk({16'h0, pend}, 32'h20);
      repeat (4) @(posedge clk);
      chk({31'h0, req}, 32'h0);
      rd(tse_pkg::OFS_LATCH, 32'h40);
      pulse(7'h20);
      rd(tse_pkg::OFS_LATCH, 32'h60);
      fin(4'h5);
      repeat (4) @(posedge clk);
      chk({16'h0, pend}, 32'h20);
      fin(4'h5);
      chk({16'h0, pend}, 32'h40);
      fin(4'h6);
   endtask : t_core
   // Masked event latches only; privileged cancel
   task automatic t_mask();
      bus(tse_pkg::OFS_MASK, 1'h1, 32'h0);
      pulse(7'h20);
      repeat (6) @(posedge clk);
      chk({31'h0, req}, 32'h0);
      prot <= 4'h0;
      bus(tse_pkg::OFS_LATCH, 1'h1, 32'h20);
      rd(tse_pkg::OFS_LATCH, 32'h0);
      prot <= 4'h2;
      rd(tse_pkg::OFS_LATCH, 32'h20);
      bus(tse_pkg::OFS_LATCH, 1'h1, 32'h20);
      rd(tse_pkg::OFS_LATCH, 32'h0);
   endtask : t_mask
   // Peripheral routing, status, remap, slow acceptance
   task automatic t_per();
      slow <= 1'h1;
      bus(tse_pkg::OFS_PMSK1, 1'h1, 32'h2000);
      bus(tse_pkg::OFS_MASK, 1'h1, 32'h1A00);
      per[45:44] <= 2'h3;
      repeat (5) @(posedge clk);
      chk({31'h0, req}, 32'h1);
      chk({28'h0, num}, 32'hC);
      wpend(16'h0);
      repeat (6) @(posedge clk);
      chk({16'h0, pend}, 32'h1000);
      rd(tse_pkg::OFS_STAT1, 32'h3000);
      fin(4'hC);
      wpend(16'h0);
      chk({16'h0, pend}, 32'h1000);
      fin(4'hC);
      bus(8'h54, 1'h1, 32'h6624_4444);
      per[45] <= 1'h1;
      wpend(16'h0);
      chk({16'h0, pend}, 32'h0200);
      fin(4'h9);
      wpend(16'h0);
      chk({16'h0, pend}, 32'h0200);
      fin(4'h9);
   endtask : t_per
   task automatic t_gie();
      @(posedge clk);
      gclr <= 1'h1;
      @(posedge clk);
      gclr <= 1'h0;
      rd(tse_pkg::OFS_CTRL, 32'h0);
      per[45] <= 1'h1;
      repeat (8) @(posedge clk);
      chk({16'h0, pend}, 32'h0);
      gset <= 1'h1;
      @(posedge clk);
      gset <= 1'h0;
      wpend(16'h0);
      chk({16'h0, pend}, 32'h0200);
      fin(4'h9);
   endtask : t_gie
   task automatic t_wake();
      bus(tse_pkg::OFS_WAKE0, 1'h1, 32'h1);
      idle   <= 1'h1;
      per[0] <= 1'h1;
      repeat (3) @(posedge clk);
      chk({31'h0, wake}, 32'h1);
      idle <= 1'h0;
      repeat (3) @(posedge clk);
      chk({31'h0, wake}, 32'h0);
   endtask : t_wake
   task automatic test_done();
      if (fails == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done
   // Watchdog
   initial begin
      #160000;
      fails++;
      test_done();
   end
   // Main sequence
   initial begin
      {rstn, haddr, htrans, hwrite, hwdata, cev, per, slow, idle, gset, gclr, ret, rnum} = '0;
      prot = 4'h2;
      repeat (3) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) @(posedge clk);
      t_reset();
      t_core();
      t_mask();
      t_per();
      t_gie();
      t_wake();
      test_done();
   end
endmodule : test_two_stage_event_controller
`default_nettype wire
